//--- rtl/descriptor_chain_intr_queue.v
// Purpose: message descriptor chain walker and interrupt queue writer of a DMA engine
// Assumes: mem_* is a same-clock request/acknowledge port to the PCI bus master
// Notes: one memory operation at a time; queue load, then walk, then interrupt write
// Functional notes
// - next link forms dword address, low bits zero
// - data buffer pointer is any byte address
// - per-direction inhibit selects status write-back
// - inhibit clear: write status, follow link, update
// - inhibit set: read next, store its link
// - interrupt descriptors written to queue as master
// - service request loads queue settings from memory
// - queue base at 00h, length at 04h
// - queue base low two bits held zero
// - queue length 15 bits, upper bits zero
// - queue length zero-based, minimum value one; a zero from a write or a load is kept as zero
// - masked interrupt types are never generated
// - status word carries owner, end, length, error
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "descriptor_chain_regs.vh"
module descriptor_chain_intr_queue #(
   parameter LEN_W = 15
) (
   input wire aclk, // clock
   input wire aresetn, // sync reset, active low
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // byte enables
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output wire [1:0] s_axi_bresp, // write response
   output wire s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output wire [31:0] s_axi_rdata, // read data
   output wire [1:0] s_axi_rresp, // read response
   output wire s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   output reg mem_req, // memory request, held until ack
   output reg mem_we, // 1 write, 0 read
   output reg [31:0] mem_addr, // memory byte address
   output reg [31:0] mem_wdata, // memory write data
   input wire mem_ack, // request done, read data valid
   input wire [31:0] mem_rdata, // memory read data
   input wire msg_end, // end of message pulse
   input wire msg_dir, // 1 transmit, 0 receive
   input wire [31:0] msg_ptr_loc, // shared-memory address of the message pointer
   input wire message_end_flag, // end of message in this buffer
   input wire [13:0] received_octet_count, // octets in this buffer
   input wire [3:0] rx_error, // receive error code
   output reg walk_ready, // msg_end accepted
   output reg walk_done, // descriptor advance finished pulse
   output reg [31:0] desc_buf_word, // buffer descriptor of new message
   output reg [31:0] buffer_byte_addr, // data pointer of new message
   input wire intr_req, // interrupt descriptor pulse
   input wire [4:0] intr_type, // interrupt type for masking
   input wire [31:0] intr_desc, // interrupt descriptor word
   output reg intr_ready, // intr_req accepted
   output reg irq // level interrupt
);
   localparam [3:0] ST_IDLE = 4'h0, ST_RD_MPTR = 4'h1, ST_WR_STAT = 4'h2, ST_RD_LINK = 4'h3;
   localparam [3:0] ST_RD_BUF = 4'h4, ST_RD_DATA = 4'h5, ST_RD_NLINK = 4'h6, ST_WR_MPTR = 4'h7;
   localparam [3:0] ST_RD_QBASE = 4'h8, ST_RD_QLEN = 4'h9, ST_WR_INTR = 4'hA;
   wire wr_en, cmd_write, op_done, intr_masked;
   wire [7:0] wr_addr, rd_addr;
   wire [3:0] wr_strb;
   wire [31:0] wr_data, slot_addr;
   wire [LEN_W-1:0] slot;
   reg [31:0] rd_word, intr_queue_base, intr_queue_length, ctrl, svc_addr, type_mask;
   reg [`IRQ_BITS-1:0] irq_status, irq_enable, irq_set;
   reg [3:0] state, next_state;
   reg load_pend, walk_pend, walk_inhibit, intr_pend, op_we;
   reg [31:0] walk_status, walk_ptr_loc, cur_desc, next_desc, intr_word, op_addr, op_wdata;
   // byte-lane merge of a register write
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction
   // dword alignment of a link or queue base
   function [31:0] dword_addr;
      input [31:0] raw;
      begin
         dword_addr = raw & `DWORD_ALIGN_MASK;
      end
   endfunction
   axil_reg_port u_port (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .rd_addr(rd_addr), .rd_word(rd_word)
   );
   intr_slot_ring #(.LEN_W(LEN_W)) u_ring (
      .aclk(aclk), .aresetn(aresetn), .restart(state == ST_RD_QLEN && op_done),
      .advance(state == ST_WR_INTR && op_done), .last_slot(intr_queue_length[LEN_W-1:0]),
      .base(intr_queue_base), .slot(slot), .slot_addr(slot_addr)
   );
   // command strobe, memory handshake and type masking
   assign cmd_write = wr_en && wr_addr == `REG_COMMAND && wr_strb[0] && wr_data[`CMD_LOAD_QUEUE];
   assign op_done = mem_req && mem_ack;
   assign intr_masked = type_mask[intr_type];
   // register writes; queue fields trimmed on every load path
   always @(posedge aclk) begin
      if (!aresetn) begin
         intr_queue_base <= `RST_IQ_BASE;
         intr_queue_length <= `RST_IQ_LENGTH;
         ctrl <= `RST_CTRL;
         svc_addr <= 32'h00000000;
         type_mask <= `RST_TYPE_MASK;
         irq_enable <= {`IRQ_BITS{1'b0}};
      end else begin
         if (wr_en) begin
            case (wr_addr)
               `REG_IQ_BASE: intr_queue_base <= dword_addr(merge(intr_queue_base, wr_data, wr_strb));
               `REG_IQ_LENGTH: intr_queue_length <= merge(intr_queue_length, wr_data, wr_strb)
                  & 32'h00007FFF;
               `REG_CTRL: ctrl <= merge(ctrl, wr_data, wr_strb) & 32'h00000007;
               `REG_SVC_ADDR: svc_addr <= dword_addr(merge(svc_addr, wr_data, wr_strb));
               `REG_TYPE_MASK: type_mask <= merge(type_mask, wr_data, wr_strb);
               `REG_IRQ_ENABLE: irq_enable <= wr_strb[0] ? wr_data[`IRQ_BITS-1:0] : irq_enable;
               default: ;
            endcase
         end
         if (state == ST_RD_QBASE && op_done) begin
            intr_queue_base <= dword_addr(mem_rdata);
         end
         if (state == ST_RD_QLEN && op_done) begin
            intr_queue_length <= mem_rdata & 32'h00007FFF;
         end
      end
   end
   // register read mux
   always @* begin
      case (rd_addr)
         `REG_IQ_BASE: rd_word = intr_queue_base;
         `REG_IQ_LENGTH: rd_word = intr_queue_length;
         `REG_CTRL: rd_word = ctrl;
         `REG_SVC_ADDR: rd_word = svc_addr;
         `REG_TYPE_MASK: rd_word = type_mask;
         `REG_IRQ_STATUS: rd_word = {28'h0000000, irq_status};
         `REG_IRQ_ENABLE: rd_word = {28'h0000000, irq_enable};
         `REG_ENGINE_STATE: rd_word = {state, load_pend, walk_pend, intr_pend, {(25-LEN_W){1'b0}}, slot};
         default: rd_word = 32'h00000000;
      endcase
   end

   // sticky status: set wins over a clear in the same cycle
   always @* begin
      irq_set = {`IRQ_BITS{1'b0}};
      irq_set[`IRQ_WALK_DONE] = state == ST_WR_MPTR && op_done;
      irq_set[`IRQ_QUEUE_LOADED] = state == ST_RD_QLEN && op_done;
      irq_set[`IRQ_DESC_WRITTEN] = state == ST_WR_INTR && op_done;
      irq_set[`IRQ_DESC_MASKED] = intr_req && intr_ready && intr_masked;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= {`IRQ_BITS{1'b0}};
         irq <= 1'b0;
      end else begin
         if (wr_en && wr_addr == `REG_IRQ_CLEAR) begin
            irq_status <= (irq_status & ~wr_data[`IRQ_BITS-1:0]) | irq_set;
         end else begin
            irq_status <= irq_status | irq_set;
         end
         irq <= |(irq_status & irq_enable);
      end
   end

   // pending work: queue load, message end, interrupt descriptor
   always @(posedge aclk) begin
      if (!aresetn) begin
         load_pend <= 1'b0;
         walk_pend <= 1'b0;
         walk_ready <= 1'b1;
         walk_inhibit <= 1'b0;
         walk_status <= 32'h00000000;
         walk_ptr_loc <= 32'h00000000;
         intr_pend <= 1'b0;
         intr_ready <= 1'b1;
         intr_word <= 32'h00000000;
      end else begin
         if (state == ST_RD_QLEN && op_done) begin
            load_pend <= 1'b0;
         end
         if (cmd_write) begin
            load_pend <= 1'b1;
         end
         if (msg_end && walk_ready) begin
            walk_pend <= 1'b1;
            walk_ready <= 1'b0;
            walk_ptr_loc <= dword_addr(msg_ptr_loc);
            walk_inhibit <= msg_dir ? ctrl[`CTRL_TX_INHIBIT] : ctrl[`CTRL_RX_INHIBIT];
            walk_status <= 32'h00000000;
            walk_status[`BSD_OWNER] <= ~msg_dir;
            walk_status[`BSD_EOM] <= message_end_flag;
            walk_status[`BSD_LEN_MSB:0] <= received_octet_count;
            walk_status[`BSD_ERR_LSB +: 4] <= msg_dir ? 4'h0 : rx_error;
         end else if (state == ST_WR_MPTR && op_done) begin
            walk_pend <= 1'b0;
            walk_ready <= 1'b1;
         end
         if (intr_req && intr_ready && !intr_masked) begin
            intr_pend <= 1'b1;
            intr_ready <= 1'b0;
            intr_word <= intr_desc;
         end else if (state == ST_WR_INTR && op_done) begin
            intr_pend <= 1'b0;
            intr_ready <= 1'b1;
         end
      end
   end

   // memory operation of each state
   always @* begin
      op_addr = 32'h00000000;
      op_we = 1'b0;
      op_wdata = 32'h00000000;
      case (state)
         ST_RD_MPTR: op_addr = walk_ptr_loc;
         ST_WR_STAT: begin
            op_addr = cur_desc + `DESC_BUF_OFS;
            op_we = 1'b1;
            op_wdata = walk_status;
         end
         ST_RD_LINK: op_addr = cur_desc + `DESC_LINK_OFS;
         ST_RD_BUF: op_addr = next_desc + `DESC_BUF_OFS;
         ST_RD_DATA: op_addr = next_desc + `DESC_DATA_OFS;
         ST_RD_NLINK: op_addr = next_desc + `DESC_LINK_OFS;
         ST_WR_MPTR: begin
            op_addr = walk_ptr_loc;
            op_we = 1'b1;
            op_wdata = next_desc;
         end
         ST_RD_QBASE: op_addr = svc_addr + `QDESC_BASE_OFS;
         ST_RD_QLEN: op_addr = svc_addr + `QDESC_LEN_OFS;
         ST_WR_INTR: begin
            op_addr = slot_addr;
            op_we = 1'b1;
            op_wdata = intr_word;
         end
         default: ;
      endcase
   end

   // sequence of operations
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (ctrl[`CTRL_BUS_MASTER]) begin
               if (load_pend) begin
                  next_state = ST_RD_QBASE;
               end else if (walk_pend) begin
                  next_state = ST_RD_MPTR;
               end else if (intr_pend) begin
                  next_state = ST_WR_INTR;
               end
            end
         end
         ST_RD_MPTR: next_state = walk_inhibit ? ST_RD_BUF : ST_WR_STAT;
         ST_WR_STAT: next_state = ST_RD_LINK;
         ST_RD_LINK: next_state = ST_RD_BUF;
         ST_RD_BUF: next_state = ST_RD_DATA;
         ST_RD_DATA: next_state = walk_inhibit ? ST_RD_NLINK : ST_WR_MPTR;
         ST_RD_NLINK: next_state = ST_WR_MPTR;
         ST_WR_MPTR: next_state = ST_IDLE;
         ST_RD_QBASE: next_state = ST_RD_QLEN;
         ST_RD_QLEN: next_state = ST_IDLE;
         ST_WR_INTR: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // issue, hold until acknowledged, capture and advance
   always @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 32'h00000000;
         mem_wdata <= 32'h00000000;
         cur_desc <= 32'h00000000;
         next_desc <= 32'h00000000;
         walk_done <= 1'b0;
         desc_buf_word <= 32'h00000000;
         buffer_byte_addr <= 32'h00000000;
      end else begin
         walk_done <= 1'b0;
         if (state == ST_IDLE) begin
            state <= next_state;
         end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= op_we;
            mem_addr <= op_addr;
            mem_wdata <= op_wdata;
         end else if (mem_ack) begin
            mem_req <= 1'b0;
            state <= next_state;
            case (state)
               ST_RD_MPTR: begin
                  cur_desc <= dword_addr(mem_rdata);
                  next_desc <= dword_addr(mem_rdata);
               end
               ST_RD_LINK: next_desc <= dword_addr(mem_rdata);
               ST_RD_BUF: desc_buf_word <= mem_rdata;
               ST_RD_DATA: buffer_byte_addr <= mem_rdata;
               ST_RD_NLINK: next_desc <= dword_addr(mem_rdata);
               ST_WR_MPTR: walk_done <= 1'b1;
               default: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/descriptor_chain_regs.vh
// Purpose: register offsets, field positions, reset values and descriptor layout
// Assumes: 32-bit AXI4-Lite register port, byte addresses
// Notes: definitions only
`ifndef DESCRIPTOR_CHAIN_REGS_VH
`define DESCRIPTOR_CHAIN_REGS_VH

// register byte offsets
`define REG_IQ_BASE 8'h00
`define REG_IQ_LENGTH 8'h04
`define REG_CTRL 8'h08
`define REG_SVC_ADDR 8'h0C
`define REG_COMMAND 8'h10
`define REG_TYPE_MASK 8'h14
`define REG_IRQ_STATUS 8'h18
`define REG_IRQ_CLEAR 8'h1C
`define REG_IRQ_ENABLE 8'h20
`define REG_ENGINE_STATE 8'h24

// control bits
`define CTRL_BUS_MASTER 0
`define CTRL_TX_INHIBIT 1
`define CTRL_RX_INHIBIT 2
// command bits
`define CMD_LOAD_QUEUE 0

// reset values
`define RST_IQ_BASE 32'h00000000
`define RST_IQ_LENGTH 32'h00000001
`define RST_CTRL 32'h00000000
`define RST_TYPE_MASK 32'h00000000

// field layout
`define IQ_LENGTH_MSB 14
`define DWORD_ALIGN_MASK 32'hFFFFFFFC

// message descriptor dword offsets in shared memory
`define DESC_BUF_OFS 32'h00000000
`define DESC_DATA_OFS 32'h00000004
`define DESC_LINK_OFS 32'h00000008
// queue descriptor copy offsets
`define QDESC_BASE_OFS 32'h00000000
`define QDESC_LEN_OFS 32'h00000004

// buffer status word fields
`define BSD_OWNER 31
`define BSD_EOM 29
`define BSD_ERR_LSB 16
`define BSD_LEN_MSB 13

// interrupt status bits
`define IRQ_WALK_DONE 0
`define IRQ_QUEUE_LOADED 1
`define IRQ_DESC_WRITTEN 2
`define IRQ_DESC_MASKED 3
`define IRQ_BITS 4

`endif

//--- rtl/axil_reg_port.v
// Purpose: AXI4-Lite slave front end, turns bus transfers into register strobes
// Assumes: one write and one read outstanding at most
// Notes: read data sampled from rd_word one cycle after the address is taken
`timescale 1ns/1ps
`default_nettype none
module axil_reg_port (
   input wire aclk, // clock
   input wire aresetn, // sync reset, active low
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output reg s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // byte enables
   input wire s_axi_wvalid, // write data valid
   output reg s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output reg s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   output reg wr_en, // one-cycle register write
   output reg [7:0] wr_addr, // register write address
   output reg [31:0] wr_data, // register write data
   output reg [3:0] wr_strb, // register write byte enables
   output reg [7:0] rd_addr, // register read address
   input wire [31:0] rd_word // register read value
);
   reg aw_held;
   reg w_held;
   reg rd_pend;

   // write path: address and data in either order, response after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end else begin
         wr_en <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            wr_en <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read path: unmapped addresses read as zero with okay
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
         rd_addr <= 8'h00;
         rd_pend <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
            rd_pend <= 1'b1;
            s_axi_arready <= 1'b0;
         end
         if (rd_pend) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= 2'h0;
            s_axi_rvalid <= 1'b1;
            rd_pend <= 1'b0;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/intr_slot_ring.v
// Purpose: slot counter of the interrupt queue in shared memory
// Assumes: length is zero-based, in dwords
// Notes: address is the base plus four bytes per slot
`timescale 1ns/1ps
`default_nettype none
module intr_slot_ring #(
   parameter LEN_W = 15
) (
   input wire aclk, // clock
   input wire aresetn, // sync reset, active low
   input wire restart, // back to the first slot
   input wire advance, // step to the next slot
   input wire [LEN_W-1:0] last_slot, // zero-based queue length
   input wire [31:0] base, // dword-aligned queue base
   output reg [LEN_W-1:0] slot, // current slot index
   output wire [31:0] slot_addr // byte address of current slot
);
   // next slot, wrapping after the last one
   always @(posedge aclk) begin
      if (!aresetn || restart) begin
         slot <= {LEN_W{1'b0}};
      end else if (advance) begin
         if (slot >= last_slot) begin
            slot <= {LEN_W{1'b0}};
         end else begin
            slot <= slot + 1'b1;
         end
      end
   end

   assign slot_addr = base + {{(30-LEN_W){1'b0}}, slot, 2'b00};
endmodule
`default_nettype wire

//--- bench/mem_model.sv
// Purpose: shared host memory behind the engine's memory port
// Assumes: request held until acknowledged
// Notes: answers after zero to two idle cycles
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic aclk, // clock
   input wire logic mem_req, // request
   input wire logic mem_we, // write
   input wire logic [31:0] mem_addr, // byte address
   input wire logic [31:0] mem_wdata, // write data
   output logic mem_ack = 1'b0, // done
   output logic [31:0] mem_rdata = 32'h0 // read data
);
   logic [31:0] m [logic [31:0]];
   int w = 0;
   // random latency; data line toggles except when returning read data
   always @(posedge aclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (w > 0) w <= w - 1;
         else begin
            mem_ack <= 1'b1;
            w <= $urandom % 3;
            if (mem_we) m[mem_addr] = mem_wdata;
            else mem_rdata <= m[mem_addr];
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/descriptor_chain_intr_queue_assertions.sv
// Purpose: port checks on the descriptor walker
// Assumes: one clock, sync active-low reset
// Notes: bound into the top module
`timescale 1ns/1ps
`default_nettype none
module descriptor_chain_checks (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, active low
   input wire logic mem_req, // memory request
   input wire logic mem_we, // memory write
   input wire logic mem_ack, // memory done
   input wire logic [31:0] mem_addr, // memory address
   input wire logic [31:0] mem_wdata, // memory write data
   input wire logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic msg_end, // end of message
   input wire logic walk_ready, // walker idle
   input wire logic walk_done // walk finished
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // memory port, bus responses and walk sequencing
   AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_wdata) && $stable(mem_we)) else $error("memory request changed before ack");
   AST_REQ_GAP: assert property (mem_req && mem_ack |=> !mem_req) else $error("no gap after ack");
   AST_DWORD: assert property (mem_req |-> mem_addr[1:0] == 2'b00) else $error("unaligned access");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && s_axi_bresp == 2'b00)
      else $error("write response dropped");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_WALK_TAKE: assert property (msg_end && walk_ready |=> !walk_ready) else $error("walk not started");
   AST_WALK_PULSE: assert property (walk_done |=> !walk_done) else $error("walk done too long");
   AST_WALK_LAST: assert property (walk_done |-> $past(mem_req && mem_ack && mem_we))
      else $error("walk done without pointer write");
endmodule
bind descriptor_chain_intr_queue descriptor_chain_checks chk_u (.*);
`default_nettype wire

//--- bench/test_descriptor_chain_intr_queue.sv
// Purpose: self-checking bench of the descriptor walker and queue writer
// Assumes: behavioural host memory model
// Notes: expectations built from queue slot model
`timescale 1ns/1ps
`default_nettype none
module test_descriptor_chain_intr_queue;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, msg_end = 0, msg_dir = 0, message_end_flag = 0, intr_req = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [3:0] s_axi_wstrb = 4'hF, rx_error = 0;
   logic [4:0] intr_type = 0;
   logic [13:0] received_octet_count = 0;
   logic [31:0] s_axi_wdata = 0, msg_ptr_loc = 32'h100, intr_desc = 0, rd, ex, qm [2];
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req, mem_we, mem_ack;
   wire walk_ready, walk_done, intr_ready, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, desc_buf_word, buffer_byte_addr;
   int n_fail = 0, n_compared = 0, t, slot, i;
   always #5 aclk = ~aclk;
   descriptor_chain_intr_queue dut_u (.*);
   mem_model mem_u (.*);
   // compare and count
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // bus write, channels released as taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   // bus read into rd
   task rdg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      chk(s_axi_rresp, 2'h0);
      s_axi_rready <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      rdg(a);
      chk(rd, e);
   endtask
   // one end of message with random status fields
   task walk(input logic dir);
      @(posedge aclk);
      msg_dir <= dir;
      {message_end_flag, received_octet_count, rx_error} <= 19'($urandom);
      msg_end <= 1'b1;
      @(posedge aclk);
      msg_end <= 1'b0;
      for (t = 0; t < 300 && walk_done !== 1'b1; t++) @(posedge aclk);
      chk(walk_done, 1'b1);
   endtask
   task end_of_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      n_fail++;
      end_of_test;
   end
   // main sequence
   initial begin
      void'($urandom(32'h2A4EECD1));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(8'h00, 32'h0);
      rdc(8'h04, 32'h1);
      wr(8'h00, 32'h1003);
      rdc(8'h00, 32'h1000);
      wr(8'h04, 32'hFFFF8005);
      rdc(8'h04, 32'h5);
      rdc(8'h3C, 32'h0);
      $display("test registers done");
      wr(8'h08, 32'h3);
      mem_u.m[32'h100] = 32'h200;
      mem_u.m[32'h208] = 32'h303;
      mem_u.m[32'h300] = 32'hA5;
      mem_u.m[32'h304] = 32'h1235;
      mem_u.m[32'h308] = 32'h203;
      walk(1'b0);
      ex = {1'b1, 1'b0, message_end_flag, 9'h0, rx_error, 2'b00, received_octet_count};
      chk(mem_u.m[32'h200], ex);
      chk(mem_u.m[32'h100], 32'h300);
      chk(desc_buf_word, 32'hA5);
      chk(buffer_byte_addr, 32'h1235);
      walk(1'b1);
      chk(mem_u.m[32'h100], 32'h200);
      chk(mem_u.m[32'h300], 32'hA5);
      $display("test walk done");
      mem_u.m[32'h500] = 32'h2003;
      mem_u.m[32'h504] = 32'hFFFF0001;
      wr(8'h0C, 32'h500);
      wr(8'h10, 32'h1);
      rd = 0;
      for (t = 0; t < 40 && rd[1] !== 1'b1; t++) rdg(8'h18);
      rdc(8'h00, 32'h2000);
      rdc(8'h04, 32'h1);
      wr(8'h20, 32'h8);
      wr(8'h14, 32'h8);
      slot = 0;
      for (i = 0; i < 4; i++) begin
         @(posedge aclk);
         intr_type <= 5'(i);
         intr_desc <= $urandom;
         intr_req <= 1'b1;
         @(posedge aclk);
         intr_req <= 1'b0;
         @(posedge aclk);
         for (t = 0; t < 300 && intr_ready !== 1'b1; t++) @(posedge aclk);
         chk(intr_ready, 1'b1);
         if (i < 3) begin
            chk(mem_u.m[32'h2000 + 4 * slot], intr_desc);
            qm[slot] = intr_desc;
            slot = (slot == 1) ? 0 : slot + 1;
         end
      end
      rdg(8'h18);
      chk(rd[3], 1'b1);
      chk(irq, 1'b1);
      chk(mem_u.m[32'h2004], qm[1]);
      wr(8'h1C, 32'hF);
      rdc(8'h18, 32'h0);
      chk(irq, 1'b0);
      $display("test interrupt queue done");
      end_of_test;
   end
endmodule
`default_nettype wire
